/* ppm_pkg.sv */
// Package: register map, field layout, modes and timing constants of the
// parallel port mode and address block.
// Assumes a 32-bit APB master and a 50 MHz instruction-cycle clock.
package ppm_pkg;

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] PPM_OFS_MODE = 8'h00;
   localparam logic [7:0] PPM_OFS_ADDR = 8'h04;
   localparam logic [7:0] PPM_OFS_DATA = 8'h08;
   localparam int PPM_ADDR_W = 8;
   localparam int PPM_REG_W = 16;

   // ==========================================================
   // Mode register fields
   localparam int PPM_MODE_BUSY_BIT = 15;
   localparam int PPM_MODE_CFG_LSB = 0;
   localparam int PPM_MODE_CFG_MSB = 10;
   localparam logic [10:0] PPM_MODE_CFG_RST = 11'h000;

   // ==========================================================
   // Destination address register fields
   localparam int PPM_ADDR_LOW_MSB = 13;
   localparam int PPM_ADDR_CS_BIT = 14;
   localparam int PPM_ADDR_TOP_BIT = 15;
   localparam logic [15:0] PPM_ADDR_RST = 16'h0000;

   // ==========================================================
   // Data widths
   localparam int PPM_NARROW_W = 8;
   localparam int PPM_WIDE_W = 16;
   localparam logic [15:0] PPM_NARROW_MASK = 16'h00FF;
   localparam logic [15:0] PPM_WIDE_MASK = 16'hFFFF;
   localparam logic [15:0] PPM_DATA_RST = 16'h0000;

   // ==========================================================
   // Timing: one instruction cycle is one clock at 50 MHz
   localparam int PPM_CLK_MHZ = 50;
   localparam int PPM_TCY_NS = 20;
   localparam int PPM_CYC_PER_TCY = (PPM_TCY_NS * PPM_CLK_MHZ + 999) / 1000;
   localparam int PPM_CNT_W = 4;

   typedef enum logic [1:0] {
      PPM_MODE_LEGACY_SLAVE = 2'b00,
      PPM_MODE_ENH_SLAVE = 2'b01,
      PPM_MODE_MASTER2 = 2'b10,
      PPM_MODE_MASTER1 = 2'b11
   } ppm_mode_e;

   // Configuration word, same bit order as mode register bits 10:0
   typedef struct packed {
      logic wide_transfer_select;
      ppm_mode_e mode;
      logic [1:0] data_setup_wait;
      logic [3:0] strobe_wait;
      logic [1:0] hold_after_strobe_wait;
   } ppm_cfg_s;

   typedef enum logic [2:0] {
      PPM_ST_IDLE,
      PPM_ST_ADDR,
      PPM_ST_SETUP,
      PPM_ST_STROBE,
      PPM_ST_HOLD
   } ppm_state_e;

endpackage

/* ppm_sync3.sv */
// Three-stage synchroniser for pin inputs with a stable-agreement filter.
// Assumes inputs are asynchronous to pclk.
`timescale 1ns/1ns
module ppm_sync3 #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q_ff
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;

   // ==========================================================
   // Chain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // ==========================================================
   // Accept a change only once two late stages agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_ff <= '0;
      end else if (s2_ff == s3_ff) begin
         q_ff <= s3_ff;
      end
   end
endmodule

/* ppm_phase_cnt.sv */
// Phase length counter: a load of v makes the phase last v+1 cycles.
// Assumes the caller reloads on the same cycle it leaves a phase.
`timescale 1ns/1ns
module ppm_phase_cnt
   import ppm_pkg::*;
#(
   parameter int W = PPM_CNT_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   output logic last
);
   logic [W-1:0] cnt_ff;

   // ==========================================================
   // Down counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= '0;
      end else if (load) begin
         cnt_ff <= load_val;
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - W'(1);
      end
   end

   assign last = (cnt_ff == '0);
endmodule

/* ppm_parallel_port.sv */
// Parallel port mode, timing and destination address block with APB access.
// Assumes pclk is the instruction-cycle clock and pins are asynchronous.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns

// Function
// - Data register is 16 bits wide or 8 bits; access starts a transfer in master modes.
// - Two-bit mode field picks legacy slave, enhanced slave, master 2, master 1.
// - Mode value 11 is master 1; 00, 01, 10 the others.
// - Strobe field adds its value in cycles to the strobe length.
// - Strobe field zero compresses the whole transfer into one cycle.
// - Strobe field zero makes setup and hold fields ignored.
// - Hold field keeps data and address 1 to 4 cycles after strobe.
// - Address register bit 14 drives chip select one active or inactive in master modes.
// - Address bits 13 to 0 drive the address lines during transfers.
// - Address bit 15 is a further address bit on the lines.
module ppm_parallel_port
   import ppm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PPM_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata_ff,
   output logic pready_ff,
   output logic pslverr_ff,
   output logic [15:0] port_address_lines_ff,
   output logic chip_select_one_pin_ff,
   output logic read_strobe_pin_ff,
   output logic write_strobe_pin_ff,
   output logic enable_strobe_pin_ff,
   output logic byte_enable_pin_ff,
   input wire logic [15:0] port_data_lines_in,
   output logic [15:0] port_data_lines_out_ff,
   output logic port_data_lines_oe_ff,
   input wire logic host_cs_in,
   input wire logic host_rd_in,
   input wire logic host_wr_in
);
   // ==========================================================
   // Declarations
   ppm_cfg_s cfg_ff;
   logic [15:0] addr_ff;
   logic [15:0] tx_data_ff;
   logic [15:0] rx_data_ff;
   logic dir_read_ff;
   ppm_state_e state_ff;
   ppm_state_e nxt_state;
   logic cnt_load;
   logic [PPM_CNT_W-1:0] cnt_val;
   logic phase_last;
   logic [15:0] data_sync;
   logic [2:0] host_sync;
   logic host_wr_prev_ff;
   logic host_drive;
   logic host_wr_event;
   logic is_master;
   logic busy;
   logic [15:0] width_mask;
   logic sel_mode;
   logic sel_addr;
   logic sel_data;
   logic mapped;
   logic apb_access;
   logic apb_done;
   logic hold_off;
   logic start_xfer;
   logic start_read;
   logic [31:0] nxt_rdata;

   // ==========================================================
   // Pin input synchronisers
   ppm_sync3 #(
      .W(16)
   ) u_data_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(port_data_lines_in),
      .q_ff(data_sync)
   );

   ppm_sync3 #(
      .W(3)
   ) u_host_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({host_cs_in, host_rd_in, host_wr_in}),
      .q_ff(host_sync)
   );

   // ==========================================================
   // Phase counter
   ppm_phase_cnt #(
      .W(PPM_CNT_W)
   ) u_phase_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .load(cnt_load),
      .load_val(cnt_val),
      .last(phase_last)
   );

   // ==========================================================
   // Decode
   assign is_master = cfg_ff.mode[1];
   assign busy = (state_ff != PPM_ST_IDLE);
   assign width_mask = cfg_ff.wide_transfer_select ? PPM_WIDE_MASK : PPM_NARROW_MASK;
   assign sel_mode = (paddr == PPM_OFS_MODE);
   assign sel_addr = (paddr == PPM_OFS_ADDR);
   assign sel_data = (paddr == PPM_OFS_DATA);
   assign mapped = sel_mode | sel_addr | sel_data;
   assign apb_access = psel & penable;
   assign apb_done = apb_access & pready_ff;
   // Data access waits for the engine so a running transfer is never cut
   assign hold_off = sel_data & busy;
   assign start_xfer = apb_done & sel_data & is_master;
   assign start_read = ~pwrite;

   // Legacy slave uses only the 8-bit bus whatever the width bit says
   assign host_drive = ~is_master & host_sync[2] & host_sync[1];
   assign host_wr_event = ~is_master & host_sync[2] & host_sync[0] & ~host_wr_prev_ff;

   // ==========================================================
   // APB answer
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (sel_mode) begin
         nxt_rdata[PPM_MODE_CFG_MSB:PPM_MODE_CFG_LSB] = cfg_ff;
         nxt_rdata[PPM_MODE_BUSY_BIT] = busy;
      end else if (sel_addr) begin
         nxt_rdata[15:0] = addr_ff;
      end else if (sel_data) begin
         nxt_rdata[15:0] = rx_data_ff & width_mask;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else if (apb_access & ~pready_ff & ~hold_off) begin
         pready_ff <= 1'b1;
         pslverr_ff <= ~mapped;
         prdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
      end else begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end
   end

   // ==========================================================
   // Mode and timing register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ff <= ppm_cfg_s'(PPM_MODE_CFG_RST);
      end else if (apb_done & pwrite & sel_mode) begin
         cfg_ff <= ppm_cfg_s'(pwdata[PPM_MODE_CFG_MSB:PPM_MODE_CFG_LSB]);
      end
   end

   // ==========================================================
   // Destination address register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_ff <= PPM_ADDR_RST;
      end else if (apb_done & pwrite & sel_addr) begin
         addr_ff <= pwdata[15:0];
      end
   end

   // ==========================================================
   // Data registers and direction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_data_ff <= PPM_DATA_RST;
      end else if (apb_done & pwrite & sel_data) begin
         tx_data_ff <= pwdata[15:0] & width_mask;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_read_ff <= 1'b0;
      end else if (start_xfer) begin
         dir_read_ff <= start_read;
      end
   end

   // Read data are taken on the last strobe cycle; they see the pins
   // through the synchroniser, so the peripheral must drive them early
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_data_ff <= PPM_DATA_RST;
      end else if (state_ff == PPM_ST_STROBE && phase_last && dir_read_ff) begin
         rx_data_ff <= data_sync & width_mask;
      end else if (host_wr_event) begin
         rx_data_ff <= data_sync & PPM_NARROW_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_wr_prev_ff <= 1'b0;
      end else begin
         host_wr_prev_ff <= host_sync[2] & host_sync[0];
      end
   end

   // ==========================================================
   // Transfer sequencer
   always_comb begin
      nxt_state = state_ff;
      cnt_load = 1'b0;
      cnt_val = '0;
      case (state_ff)
         PPM_ST_IDLE: begin
            if (start_xfer) begin
               cnt_load = 1'b1;
               if (cfg_ff.strobe_wait == 4'h0) begin
                  nxt_state = PPM_ST_STROBE;
                  cnt_val = '0;
               end else begin
                  nxt_state = PPM_ST_ADDR;
                  cnt_val = PPM_CNT_W'(cfg_ff.data_setup_wait);
               end
            end
         end
         PPM_ST_ADDR: begin
            if (phase_last) begin
               nxt_state = PPM_ST_SETUP;
               cnt_load = 1'b1;
               cnt_val = PPM_CNT_W'(cfg_ff.data_setup_wait);
            end
         end
         PPM_ST_SETUP: begin
            if (phase_last) begin
               nxt_state = PPM_ST_STROBE;
               cnt_load = 1'b1;
               cnt_val = cfg_ff.strobe_wait;
            end
         end
         PPM_ST_STROBE: begin
            if (phase_last) begin
               cnt_load = 1'b1;
               if (cfg_ff.strobe_wait == 4'h0) begin
                  nxt_state = PPM_ST_IDLE;
               end else begin
                  nxt_state = PPM_ST_HOLD;
                  cnt_val = PPM_CNT_W'(cfg_ff.hold_after_strobe_wait);
               end
            end
         end
         PPM_ST_HOLD: begin
            if (phase_last) begin
               nxt_state = PPM_ST_IDLE;
            end
         end
         default: begin
            nxt_state = PPM_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= PPM_ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ==========================================================
   // Address and chip select pins
   // Address stays on the lines through hold, so it is held always
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_address_lines_ff <= 16'h0000;
         chip_select_one_pin_ff <= 1'b0;
      end else begin
         port_address_lines_ff <= {addr_ff[PPM_ADDR_TOP_BIT], 1'b0,
                                   addr_ff[PPM_ADDR_LOW_MSB:0]};
         chip_select_one_pin_ff <= is_master & addr_ff[PPM_ADDR_CS_BIT];
      end
   end

   // ==========================================================
   // Strobe pins, one cycle behind the sequencer state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         read_strobe_pin_ff <= 1'b0;
         write_strobe_pin_ff <= 1'b0;
         enable_strobe_pin_ff <= 1'b0;
         byte_enable_pin_ff <= 1'b0;
      end else if (state_ff == PPM_ST_STROBE) begin
         if (cfg_ff.mode == PPM_MODE_MASTER1) begin
            read_strobe_pin_ff <= dir_read_ff;
            write_strobe_pin_ff <= 1'b0;
            enable_strobe_pin_ff <= 1'b1;
            byte_enable_pin_ff <= 1'b0;
         end else begin
            read_strobe_pin_ff <= dir_read_ff;
            write_strobe_pin_ff <= ~dir_read_ff;
            enable_strobe_pin_ff <= 1'b0;
            byte_enable_pin_ff <= cfg_ff.wide_transfer_select;
         end
      end else begin
         read_strobe_pin_ff <= (cfg_ff.mode == PPM_MODE_MASTER1) & busy & dir_read_ff;
         write_strobe_pin_ff <= 1'b0;
         enable_strobe_pin_ff <= 1'b0;
         byte_enable_pin_ff <= 1'b0;
      end
   end

   // ==========================================================
   // Data pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_data_lines_out_ff <= 16'h0000;
         port_data_lines_oe_ff <= 1'b0;
      end else if (busy & ~dir_read_ff & (state_ff != PPM_ST_ADDR)) begin
         port_data_lines_out_ff <= tx_data_ff;
         port_data_lines_oe_ff <= 1'b1;
      end else if (host_drive) begin
         port_data_lines_out_ff <= tx_data_ff & PPM_NARROW_MASK;
         port_data_lines_oe_ff <= 1'b1;
      end else begin
         port_data_lines_out_ff <= 16'h0000;
         port_data_lines_oe_ff <= 1'b0;
      end
   end

endmodule

/* ppm_parallel_port_properties.sv */
// Checker for the parallel port block: shadows registers from APB writes.
// Assumes the bench never reconfigures the port while a transfer is busy.
`timescale 1ns/1ns
module ppm_parallel_port_properties
   import ppm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PPM_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata_ff,
   input wire logic pready_ff,
   input wire logic pslverr_ff,
   input wire logic [15:0] port_address_lines_ff,
   input wire logic chip_select_one_pin_ff,
   input wire logic read_strobe_pin_ff,
   input wire logic write_strobe_pin_ff,
   input wire logic enable_strobe_pin_ff,
   input wire logic byte_enable_pin_ff,
   input wire logic [15:0] port_data_lines_in,
   input wire logic [15:0] port_data_lines_out_ff,
   input wire logic port_data_lines_oe_ff,
   input wire logic host_cs_in,
   input wire logic host_rd_in,
   input wire logic host_wr_in
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================================
   // Register shadows and phase counters
   ppm_cfg_s cfg_ff;
   logic [15:0] adr_ff;
   logic [15:0] wd_ff;
   logic [7:0] since_ff;
   logic [4:0] strb_cnt_ff;
   logic [3:0] hold_cnt_ff;
   logic acc, st, strb;
   logic [15:0] msk;
   assign acc = psel && penable && pready_ff && !pslverr_ff;
   assign st = acc && paddr == PPM_OFS_DATA && cfg_ff.mode[1];
   // Master 1 read pin is a direction level, not a strobe
   assign strb = write_strobe_pin_ff || enable_strobe_pin_ff ||
                 (read_strobe_pin_ff && cfg_ff.mode == PPM_MODE_MASTER2);
   assign msk = cfg_ff.wide_transfer_select ? PPM_WIDE_MASK : PPM_NARROW_MASK;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ff <= '0;
         adr_ff <= '0;
         wd_ff <= '0;
      end else if (acc && pwrite) begin
         if (paddr == PPM_OFS_MODE) cfg_ff <= ppm_cfg_s'(pwdata[10:0]);
         if (paddr == PPM_OFS_ADDR) adr_ff <= pwdata[15:0];
         if (paddr == PPM_OFS_DATA) wd_ff <= pwdata[15:0];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         since_ff <= '0;
         strb_cnt_ff <= '0;
         hold_cnt_ff <= '0;
      end else begin
         since_ff <= st ? 8'h01 : (since_ff == 8'hFF ? since_ff : since_ff + 8'h01);
         strb_cnt_ff <= strb ? strb_cnt_ff + 5'h01 : 5'h00;
         hold_cnt_ff <= strb ? 4'h0 : hold_cnt_ff + {3'h0, port_data_lines_oe_ff};
      end
   end
   // ==========================================================
   // Assertions
   AST_WRITE_DATA: assert property (
      (write_strobe_pin_ff || (enable_strobe_pin_ff && !read_strobe_pin_ff)) |->
      port_data_lines_oe_ff && port_data_lines_out_ff == (wd_ff & msk))
      else $error("write data wrong during strobe");
   AST_SLAVE_QUIET: assert property (
      !cfg_ff.mode[1] && !$past(cfg_ff.mode[1]) |->
      !write_strobe_pin_ff && !enable_strobe_pin_ff && !chip_select_one_pin_ff)
      else $error("master pins active in slave mode");
   AST_BYTE_ENABLE: assert property (
      byte_enable_pin_ff ==
      (strb && cfg_ff.mode == PPM_MODE_MASTER2 && cfg_ff.wide_transfer_select))
      else $error("byte enable wrong");
   AST_STROBE_KIND: assert property (
      strb |-> (enable_strobe_pin_ff ? cfg_ff.mode == PPM_MODE_MASTER1 :
      cfg_ff.mode == PPM_MODE_MASTER2))
      else $error("strobe kind does not match mode");
   AST_SETUP_TIME: assert property (
      $rose(strb) && cfg_ff.strobe_wait != 4'h0 |->
      since_ff == 2 + 2 * (int'(cfg_ff.data_setup_wait) + 1))
      else $error("strobe start time wrong");
   AST_STROBE_LEN: assert property (
      $fell(strb) && cfg_ff.strobe_wait != 4'h0 |->
      strb_cnt_ff == int'(cfg_ff.strobe_wait) + 1)
      else $error("strobe length wrong");
   AST_ONE_CYCLE: assert property (
      $fell(strb) && cfg_ff.strobe_wait == 4'h0 |-> strb_cnt_ff == 5'h01)
      else $error("compressed strobe not one cycle");
   AST_WAITS_IGNORED: assert property (
      $rose(strb) && cfg_ff.strobe_wait == 4'h0 |-> since_ff == 8'h02)
      else $error("compressed transfer used waits");
   AST_HOLD_LEN: assert property (
      $fell(port_data_lines_oe_ff) && cfg_ff.mode[1] && cfg_ff.strobe_wait != 4'h0 |->
      hold_cnt_ff == int'(cfg_ff.hold_after_strobe_wait) + 1)
      else $error("hold length wrong");
   AST_CHIP_SEL: assert property (
      chip_select_one_pin_ff |-> adr_ff[PPM_ADDR_CS_BIT] || $past(adr_ff[PPM_ADDR_CS_BIT]))
      else $error("chip select without address bit");
   AST_ADDR_LINES: assert property (
      strb |-> port_address_lines_ff == (adr_ff & 16'hBFFF))
      else $error("address lines wrong");
   COV_COMPRESSED: cover property ($rose(strb) && cfg_ff.strobe_wait == 4'h0);
   COV_MASTER1_READ: cover property (enable_strobe_pin_ff && read_strobe_pin_ff);
   COV_TOP_ADDR: cover property (strb && port_address_lines_ff[PPM_ADDR_TOP_BIT]);
endmodule

bind ppm_parallel_port ppm_parallel_port_properties chk_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
   .port_address_lines_ff(port_address_lines_ff), .chip_select_one_pin_ff(chip_select_one_pin_ff),
   .read_strobe_pin_ff(read_strobe_pin_ff), .write_strobe_pin_ff(write_strobe_pin_ff),
   .enable_strobe_pin_ff(enable_strobe_pin_ff), .byte_enable_pin_ff(byte_enable_pin_ff),
   .port_data_lines_in(port_data_lines_in), .port_data_lines_out_ff(port_data_lines_out_ff),
   .port_data_lines_oe_ff(port_data_lines_oe_ff), .host_cs_in(host_cs_in),
   .host_rd_in(host_rd_in), .host_wr_in(host_wr_in));

/* ppm_periph_model.sv */
// Small external memory on the master side of the parallel port.
// Assumes addresses 0 to 15 are enough; released lines toggle every cycle.
`timescale 1ns/1ns
module ppm_periph_model
   import ppm_pkg::*;
(
   input wire logic pclk,
   input wire logic slow,
   input wire logic [15:0] addr_in,
   input wire logic rd_in,
   input wire logic wr_in,
   input wire logic en_in,
   input wire logic [15:0] dout_in,
   input wire logic oe_in,
   output logic [15:0] din_out
);
   logic [15:0] mem [0:15];
   logic [15:0] last;
   logic [1:0] lag;
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
      last = 16'h0000;
      lag = 2'b00;
   end
   always @(posedge pclk) begin
      lag <= rd_in ? {lag[0], 1'b1} : 2'b00;
      last <= din_out;
      if (wr_in || (en_in && !rd_in)) mem[addr_in[3:0]] <= dout_in;
   end
   // Slow answer only appears two cycles into the read indication
   always_comb begin
      if (!oe_in && (!slow || lag[1])) din_out = mem[addr_in[3:0]];
      else din_out = ~last;
   end
endmodule

/* tb_parallel_port_mode_and_address.sv */
// Self-checking bench for the parallel port mode and address block.
// Assumes the package, design, checker and peripheral model compile first.
`timescale 1ns/1ns
module tb_parallel_port_mode_and_address import ppm_pkg::*;;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata_ff;
   logic pready_ff, pslverr_ff, cs_pin, rd_pin, wr_pin, en_pin, oe;
   logic [15:0] adr, dout, din, mdl_dout, host_val = 16'h0;
   logic host_cs = 1'b0, host_rd = 1'b0, host_wr = 1'b0, host_drv = 1'b0, slow = 1'b0;
   logic [31:0] r;
   logic e;
   int miscompares = 0;
   int checked = 0;
   typedef struct packed {
      ppm_cfg_s cfg;
      logic slow;
      logic [15:0] a;
      logic [15:0] d;
   } ppm_tb_row_s;
   ppm_tb_row_s rows [5] = '{
      '{'{1'b0, PPM_MODE_MASTER2, 2'h0, 4'h1, 2'h0}, 1'b0, 16'h0003, 16'h12A5},
      '{'{1'b1, PPM_MODE_MASTER2, 2'h3, 4'h2, 2'h3}, 1'b0, 16'h8005, 16'hBEEF},
      '{'{1'b1, PPM_MODE_MASTER1, 2'h1, 4'h0, 2'h2}, 1'b0, 16'h4007, 16'h5A5A},
      '{'{1'b0, PPM_MODE_MASTER1, 2'h2, 4'hF, 2'h1}, 1'b1, 16'h3FF9, 16'h77C3},
      '{'{1'b1, PPM_MODE_MASTER1, 2'h0, 4'h3, 2'h3}, 1'b0, 16'hC00A, 16'h0F0F}};
   assign din = host_drv ? host_val : mdl_dout;
   always #10 pclk = ~pclk;
   ppm_parallel_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
      .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .port_address_lines_ff(adr),
      .chip_select_one_pin_ff(cs_pin), .read_strobe_pin_ff(rd_pin),
      .write_strobe_pin_ff(wr_pin), .enable_strobe_pin_ff(en_pin), .byte_enable_pin_ff(),
      .port_data_lines_in(din), .port_data_lines_out_ff(dout), .port_data_lines_oe_ff(oe),
      .host_cs_in(host_cs), .host_rd_in(host_rd), .host_wr_in(host_wr));
   ppm_periph_model mdl_u (.pclk(pclk), .slow(slow), .addr_in(adr), .rd_in(rd_pin),
      .wr_in(wr_pin), .en_in(en_pin), .dout_in(dout), .oe_in(oe), .din_out(mdl_dout));
   // ==========================================================
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t value %h expected %h", $time, got, exp);
      end
   endtask
   // Holds the request until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready_ff !== 1'b1);
      r = prdata_ff;
      e = pslverr_ff;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_idle();
      do apb(1'b0, PPM_OFS_MODE, 32'h0); while (r[PPM_MODE_BUSY_BIT] !== 1'b0);
   endtask
   task automatic end_sim();
      if (miscompares == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #1500000;
      miscompares++;
      end_sim();
   end
   // ==========================================================
   // Main sequence
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      chk({15'h0, cs_pin, adr}, 32'h0);
      apb(1'b0, PPM_OFS_MODE, 32'h0);
      chk(r, 32'h0);
      foreach (rows[i]) begin
         apb(1'b1, PPM_OFS_MODE, {21'h0, rows[i].cfg});
         apb(1'b0, PPM_OFS_MODE, 32'h0);
         chk(r, {21'h0, rows[i].cfg});
         apb(1'b1, PPM_OFS_ADDR, {16'h0, rows[i].a});
         slow <= rows[i].slow;
         apb(1'b1, PPM_OFS_DATA, {16'h0, rows[i].d});
         wait_idle();
         apb(1'b0, PPM_OFS_DATA, 32'h0);
         wait_idle();
         apb(1'b0, PPM_OFS_DATA, 32'h0);
         chk(r, {16'h0, rows[i].d &
            (rows[i].cfg.wide_transfer_select ? 16'hFFFF : 16'h00FF)});
         wait_idle();
         chk({31'h0, cs_pin}, {31'h0, rows[i].a[PPM_ADDR_CS_BIT]});
         chk({16'h0, adr}, {16'h0, rows[i].a & 16'hBFFF});
      end
      // Data access while the engine runs is stalled, not lost
      apb(1'b1, PPM_OFS_DATA, 32'h0000_1234);
      apb(1'b0, PPM_OFS_MODE, 32'h0);
      chk({31'h0, r[PPM_MODE_BUSY_BIT]}, 32'h1);
      apb(1'b0, PPM_OFS_DATA, 32'h0);
      chk(r, 32'h0F0F);
      wait_idle();
      apb(1'b0, PPM_OFS_DATA, 32'h0);
      chk(r, 32'h1234);
      wait_idle();
      apb(1'b1, PPM_OFS_MODE, 32'hFFFF);
      apb(1'b0, PPM_OFS_MODE, 32'h0);
      chk(r, 32'h07FF);
      apb(1'b1, 8'h0C, 32'hFFFF);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, PPM_OFS_MODE, 32'h0100);
      apb(1'b0, PPM_OFS_MODE, 32'h0);
      chk(r, 32'h0100);
      // Legacy slave: a host write lands in the data register
      apb(1'b1, PPM_OFS_MODE, 32'h0);
      host_val <= 16'h12A5;
      host_drv <= 1'b1;
      host_cs <= 1'b1;
      repeat (2) @(posedge pclk);
      host_wr <= 1'b1;
      repeat (8) @(posedge pclk);
      host_wr <= 1'b0;
      repeat (8) @(posedge pclk);
      host_cs <= 1'b0;
      host_drv <= 1'b0;
      apb(1'b0, PPM_OFS_DATA, 32'h0);
      chk(r, 32'h00A5);
      chk({31'h0, cs_pin}, 32'h0);
      apb(1'b1, PPM_OFS_DATA, 32'h003C);
      host_cs <= 1'b1;
      host_rd <= 1'b1;
      repeat (8) @(posedge pclk);
      chk({23'h0, oe, dout[7:0]}, 32'h013C);
      host_cs <= 1'b0;
      host_rd <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, PPM_OFS_ADDR, 32'h0);
      chk(r, 32'h0);
      end_sim();
   end
endmodule
